/* File: design/tmc_pkg.sv */
package tmc_pkg;
  localparam int TMC_NUM = 4;
  localparam int TMC_DW = 16;
  localparam int TMC_AW = 8;
  localparam int TMC_WIDTH [TMC_NUM] = '{10, 10, 10, 16};
  localparam logic [7:0] TMC_HI_MASK [TMC_NUM] =
    '{8'h03, 8'h03, 8'h03, 8'hFF};
  localparam logic [4:0] TMC_OFS_C0 = 5'h00;
  localparam logic [4:0] TMC_OFS_C1 = 5'h04;
  localparam logic [4:0] TMC_OFS_DL = 5'h08;
  localparam logic [4:0] TMC_OFS_DH = 5'h0C;
  localparam logic [4:0] TMC_OFS_AL = 5'h10;
  localparam logic [4:0] TMC_OFS_AH = 5'h14;
  localparam logic [7:0] TMC_OFS_PINSEL = 8'h80;
  localparam int TMC_TSEL_LSB = 5;
  localparam logic [7:0] TMC_CTRL_RST = 8'h00;
  localparam logic [3:0] TMC_PINSEL_RST = 4'h0;
  localparam logic [5:0] TMC_DIV4 = 6'h03;
  localparam logic [5:0] TMC_DIV16 = 6'h0F;
  localparam logic [5:0] TMC_DIV64 = 6'h3F;
  localparam int TMC_C0_PAU = 7;
  localparam int TMC_C0_CK_LSB = 4;
  localparam int TMC_C0_ON = 3;
  localparam int TMC_C0_RP_LSB = 0;
  localparam int TMC_C1_M_LSB = 6;
  localparam int TMC_C1_IO_LSB = 4;
  localparam int TMC_C1_OC = 3;
  localparam int TMC_C1_POL = 2;
  localparam int TMC_C1_DPX = 1;
  localparam int TMC_C1_CCLR = 0;
  typedef enum logic [2:0] {TMC_CK_SYS4 = 3'h0, TMC_CK_SYS = 3'h1,
    TMC_CK_H16 = 3'h2, TMC_CK_H64 = 3'h3, TMC_CK_SUB = 3'h4,
    TMC_CK_RSVD = 3'h5, TMC_CK_EXT_R = 3'h6, TMC_CK_EXT_F = 3'h7} tmc_clk_t;
  typedef enum logic [1:0] {TMC_M_CMP = 2'h0, TMC_M_UNDEF = 2'h1,
    TMC_M_PWM = 2'h2, TMC_M_TMR = 2'h3} tmc_mode_t;
  typedef enum logic [1:0] {TMC_IO_KEEP = 2'h0, TMC_IO_LOW = 2'h1,
    TMC_IO_HIGH = 2'h2, TMC_IO_TOG = 2'h3} tmc_io_t;
endpackage

/* File: design/tmc_core_if.sv */
`timescale 1ns/100ps
interface tmc_core_if;
  logic [7:0] timer_output_pin_select;
  logic [7:0] ctrl1;
  logic [15:0] cmp_a;
  logic tick_div4;
  logic tick_div16;
  logic tick_div64;
  logic tick_sub;
  logic ext_level;
  logic [15:0] count;
  logic match_a;
  logic match_p;
  logic out_drive;
  logic out_level;
  modport regs (output timer_output_pin_select, ctrl1, cmp_a, tick_div4, tick_div16,
    tick_div64, tick_sub, ext_level,
    input count, match_a, match_p, out_drive, out_level);
  modport core (input timer_output_pin_select, ctrl1, cmp_a, tick_div4, tick_div16,
    tick_div64, tick_sub, ext_level,
    output count, match_a, match_p, out_drive, out_level);
endinterface

/* File: design/tmc_core.sv */
`timescale 1ns/100ps
module tmc_core
  import tmc_pkg::*;
#(
  parameter int W = 10
)
(
  input wire logic pclk,
  input wire logic presetn,
  tmc_core_if.core bus
);
  logic [W-1:0] count;
  logic [W-1:0] cnt_inc;
  logic [W-1:0] p_val;
  logic [W-1:0] a_val;
  logic [2:0] rp;
  logic run, pause, oc, pol, dpx, cclr;
  logic run_q, ext_q, out_state, tick, step, run_rise, clr;
  logic pwm_act, pwm_lvl;
  tmc_clk_t ck;
  tmc_mode_t mode;
  tmc_io_t io;

  assign run = bus.timer_output_pin_select[TMC_C0_ON];
  assign pause = bus.timer_output_pin_select[TMC_C0_PAU];
  assign ck = tmc_clk_t'(bus.timer_output_pin_select[TMC_C0_CK_LSB +: 3]);
  assign rp = bus.timer_output_pin_select[TMC_C0_RP_LSB +: 3];
  assign mode = tmc_mode_t'(bus.ctrl1[TMC_C1_M_LSB +: 2]);
  assign io = tmc_io_t'(bus.ctrl1[TMC_C1_IO_LSB +: 2]);
  assign oc = bus.ctrl1[TMC_C1_OC];
  assign pol = bus.ctrl1[TMC_C1_POL];
  assign dpx = bus.ctrl1[TMC_C1_DPX];
  assign cclr = bus.ctrl1[TMC_C1_CCLR];
  assign a_val = bus.cmp_a[W-1:0];
  assign p_val = {rp, {(W-3){1'b0}}};
  assign cnt_inc = count + 1'b1;
  assign run_rise = run & ~run_q;

  always_comb
  begin
    case (ck)
      TMC_CK_SYS4: tick = bus.tick_div4;
      TMC_CK_SYS: tick = 1'b1;
      TMC_CK_H16: tick = bus.tick_div16;
      TMC_CK_H64: tick = bus.tick_div64;
      TMC_CK_SUB: tick = bus.tick_sub;
      TMC_CK_EXT_R: tick = bus.ext_level & ~ext_q;
      TMC_CK_EXT_F: tick = ~bus.ext_level & ext_q;
      default: tick = 1'b0;
    endcase
  end

  assign step = tick & run & ~pause & ~run_rise;
  // a zero period value means full overflow
  assign bus.match_p = step & ((rp == 3'h0) ? (&count)
    : (cnt_inc == p_val));
  assign bus.match_a = step & (cnt_inc == a_val);
  // pwm restarts on the period match, or on the compare A match when dpx is set
  assign clr = (mode == TMC_M_PWM) ? (dpx ? bus.match_a : bus.match_p)
    : (cclr ? bus.match_a : bus.match_p);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= 1'b0;
      ext_q <= 1'b0;
    end
    else
    begin
      run_q <= run;
      ext_q <= bus.ext_level;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else if (run_rise)
      count <= '0;
    else if (step)
      count <= clr ? '0 : cnt_inc;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_state <= 1'b0;
    else if (run_rise)
      out_state <= oc;
    else if (bus.match_a && mode == TMC_M_CMP)
    begin
      case (io)
        TMC_IO_LOW: out_state <= 1'b0;
        TMC_IO_HIGH: out_state <= 1'b1;
        TMC_IO_TOG: out_state <= ~out_state;
        default: out_state <= out_state;
      endcase
    end
  end

  assign pwm_act = dpx ? (count < p_val) : (count < a_val);

  always_comb
  begin
    case (io)
      TMC_IO_LOW: pwm_lvl = oc;
      TMC_IO_HIGH: pwm_lvl = pwm_act ? oc : ~oc;
      default: pwm_lvl = ~oc;
    endcase
  end

  // timer/counter and undefined modes leave the pins alone
  assign bus.out_drive = run & (mode == TMC_M_CMP
    || mode == TMC_M_PWM);
  assign bus.out_level = ((mode == TMC_M_PWM) ? pwm_lvl : out_state) ^ pol;
  assign bus.count = TMC_DW'(count);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_run_clear: assert property ($rose(run) |=> count == '0)
    else $error("counter not cleared on run start");
  a_off_hold: assert property (!run |=> $stable(count))
    else $error("counter moved while off");
  a_wrap_zero: assert property (step && (&count) |=> count == '0)
    else $error("counter did not wrap");
  a_p_period: assert property (step && rp != 3'h0
    && cnt_inc[W-1 -: 3] == rp && cnt_inc[W-4:0] == '0
    |-> bus.match_p)
    else $error("period match missed");
  a_ext_count: assert property (run && !pause && !run_rise && !clr
    && ck == TMC_CK_EXT_F && $fell(bus.ext_level)
    |=> count == $past(cnt_inc))
    else $error("falling pin edge not counted");
  a_rsvd_stop: assert property (ck == TMC_CK_RSVD && !run_rise
    |=> $stable(count))
    else $error("reserved clock counted");
  a_cmp_toggle: assert property (bus.match_a && mode == TMC_M_CMP
    && io == TMC_IO_TOG && !run_rise
    |=> out_state != $past(out_state))
    else $error("toggle not applied");
endmodule // tmc_core

/* File: design/tmc_top.sv */
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module tmc_top
  import tmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [TMC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TMC_NUM-1:0] external_count_input,
  input wire logic sub_clock,
  output logic [TMC_NUM-1:0] timer_output_first,
  output logic [TMC_NUM-1:0] timer_output_first_oe,
  output logic [TMC_NUM-1:0] timer_output_second,
  output logic [TMC_NUM-1:0] timer_output_second_oe,
  output logic [TMC_NUM-1:0] match_a_event,
  output logic [TMC_NUM-1:0] match_p_event
);
  logic [7:0] timer_output_pin_select [TMC_NUM];
  logic [7:0] ctrl1 [TMC_NUM];
  logic [15:0] cmp_a [TMC_NUM];
  logic [15:0] cnt [TMC_NUM];
  logic [7:0] hold [TMC_NUM];
  logic [TMC_NUM-1:0] pin_sel;
  logic [TMC_NUM-1:0] lvl_w;
  logic [TMC_NUM-1:0] drive_w;
  logic [TMC_NUM-1:0] ma_w;
  logic [TMC_NUM-1:0] mp_w;
  logic [5:0] pre;
  logic sub_q;
  logic tick_sub;
  logic [7:0] snap_low;
  logic [7:0] next_byte;
  logic [7:0] next_snap;
  logic [1:0] tsel;
  logic [4:0] rsel;
  logic hit_pin;
  logic hit_tmr;
  logic mapped;
  logic setup;
  logic acc_wr;
  logic acc_rd;

  // bus decode
  assign tsel = paddr[TMC_TSEL_LSB +: 2];
  assign rsel = paddr[4:0];
  assign hit_pin = (paddr == TMC_OFS_PINSEL);
  assign hit_tmr = (paddr < TMC_OFS_PINSEL) && (rsel == TMC_OFS_C0
    || rsel == TMC_OFS_C1 || rsel == TMC_OFS_DL || rsel == TMC_OFS_DH
    || rsel == TMC_OFS_AL || rsel == TMC_OFS_AH);
  assign mapped = hit_pin | hit_tmr;
  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pwrite & mapped;
  assign acc_rd = psel & penable & ~pwrite & mapped;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // shared prescaler for the divided internal clocks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre <= '0;
      sub_q <= 1'b0;
    end
    else
    begin
      pre <= pre + 1'b1;
      sub_q <= sub_clock;
    end
  end

  assign tick_sub = sub_clock & ~sub_q;

  // one compact core per timer, width from the table
  generate
    for (genvar g = 0; g < TMC_NUM; g++)
    begin : g_tmr
      tmc_core_if cif();
      assign cif.timer_output_pin_select = timer_output_pin_select[g];
      assign cif.ctrl1 = ctrl1[g];
      assign cif.cmp_a = cmp_a[g];
      assign cif.tick_div4 = ((pre & TMC_DIV4) == TMC_DIV4);
      assign cif.tick_div16 = ((pre & TMC_DIV16) == TMC_DIV16);
      assign cif.tick_div64 = (pre == TMC_DIV64);
      assign cif.tick_sub = tick_sub;
      assign cif.ext_level = external_count_input[g];
      assign cnt[g] = cif.count;
      assign ma_w[g] = cif.match_a;
      assign mp_w[g] = cif.match_p;
      assign drive_w[g] = cif.out_drive;
      assign lvl_w[g] = cif.out_level;
      tmc_core #(
        .W(TMC_WIDTH[g])
      ) u_core (
        .pclk(pclk),
        .presetn(presetn),
        .bus(cif)
      );
    end
  endgenerate

  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_output_pin_select <= '{default: TMC_CTRL_RST};
      ctrl1 <= '{default: TMC_CTRL_RST};
    end
    else if (acc_wr && hit_tmr && rsel == TMC_OFS_C0)
      timer_output_pin_select[tsel] <= pwdata[7:0];
    else if (acc_wr && hit_tmr && rsel == TMC_OFS_C1)
      ctrl1[tsel] <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_sel <= TMC_PINSEL_RST;
    else if (acc_wr && hit_pin)
      pin_sel <= pwdata[TMC_NUM-1:0];
  end

  // holding buffer: one per timer, shared by count and compare pairs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold <= '{default: 8'h00};
    else if (acc_wr && hit_tmr && rsel == TMC_OFS_AL)
      hold[tsel] <= pwdata[7:0];
    else if (acc_rd && hit_tmr && (rsel == TMC_OFS_DH
      || rsel == TMC_OFS_AH))
      hold[tsel] <= snap_low;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmp_a <= '{default: 16'h0000};
    else if (acc_wr && hit_tmr && rsel == TMC_OFS_AH)
      cmp_a[tsel] <= {pwdata[7:0] & TMC_HI_MASK[tsel],
        hold[tsel]};
  end

  // read data; the count has no write path at all
  always_comb
  begin
    next_byte = 8'h00;
    next_snap = snap_low;
    if (hit_pin)
      next_byte = {{(8-TMC_NUM){1'b0}}, pin_sel};
    else if (hit_tmr)
    begin
      case (rsel)
        TMC_OFS_C0: next_byte = timer_output_pin_select[tsel];
        TMC_OFS_C1: next_byte = ctrl1[tsel];
        TMC_OFS_DL: next_byte = hold[tsel];
        TMC_OFS_AL: next_byte = hold[tsel];
        TMC_OFS_DH:
        begin
          next_byte = cnt[tsel][15:8] & TMC_HI_MASK[tsel];
          next_snap = cnt[tsel][7:0];
        end
        TMC_OFS_AH:
        begin
          next_byte = cmp_a[tsel][15:8];
          next_snap = cmp_a[tsel][7:0];
        end
        default: next_byte = 8'h00;
      endcase
    end
  end

  // both bytes are sampled together in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      snap_low <= 8'h00;
    end
    else if (setup && !pwrite)
    begin
      prdata <= {24'h000000, next_byte};
      snap_low <= next_snap;
    end
  end

  // pin routing and event outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_output_first <= '0;
      timer_output_first_oe <= '0;
      timer_output_second <= '0;
      timer_output_second_oe <= '0;
      match_a_event <= '0;
      match_p_event <= '0;
    end
    else
    begin
      timer_output_first <= lvl_w;
      timer_output_second <= lvl_w;
      timer_output_first_oe <= drive_w & ~pin_sel;
      timer_output_second_oe <= drive_w & pin_sel;
      match_a_event <= ma_w;
      match_p_event <= mp_w;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr_low;
    acc_wr && hit_tmr && rsel == TMC_OFS_AL;
  endsequence

  sequence s_wr_high;
    acc_wr && hit_tmr && rsel == TMC_OFS_AH;
  endsequence

  sequence s_rd_high;
    setup && !pwrite && hit_tmr && rsel == TMC_OFS_DH ##1 acc_rd;
  endsequence

  a_pinsel_upper: assert property (setup && !pwrite && hit_pin
    |=> prdata[7:4] == 4'h0)
    else $error("pin select upper bits not zero");
  a_pin_route: assert property (1'b1 |=> timer_output_first_oe
    == $past(drive_w & ~pin_sel)
    && timer_output_second_oe == $past(drive_w & pin_sel))
    else $error("output routed to wrong pin");
  a_oe_exclusive: assert property ((timer_output_first_oe
    & timer_output_second_oe) == '0)
    else $error("both pins of a timer driven");
  a_low_buffer: assert property (s_wr_low
    |=> cmp_a[$past(tsel)] == $past(cmp_a[tsel]))
    else $error("low write changed compare value");
  a_high_commit: assert property (s_wr_low ##[2:8] s_wr_high
    |=> cmp_a[$past(tsel)][7:0] == $past(hold[tsel]))
    else $error("buffered low byte not committed");
  a_read_capture: assert property (s_rd_high
    |=> hold[$past(tsel)] == $past(cnt[tsel][7:0], 2))
    else $error("low byte not captured on high read");
  a_event_delay: assert property (ma_w != '0
    |=> match_a_event == $past(ma_w))
    else $error("match event lost");
  a_err_unmapped: assert property (psel && penable && !mapped
    |-> pslverr && pready)
    else $error("unmapped access not flagged");
endmodule // tmc_top

/* File: tb/tmc_partner.sv */
`timescale 1ns/100ps
module tmc_partner
  import tmc_pkg::*;
(
  input wire logic pclk,
  output logic [TMC_NUM-1:0] ext_pin,
  output logic sub_clk,
  input wire logic [TMC_NUM-1:0] pin_a,
  input wire logic [TMC_NUM-1:0] oe_a,
  input wire logic [TMC_NUM-1:0] pin_b,
  input wire logic [TMC_NUM-1:0] oe_b,
  output logic [TMC_NUM-1:0] load_a,
  output logic [TMC_NUM-1:0] load_b
);
  // loads pull an undriven pin high
  assign load_a = (pin_a & oe_a) | ~oe_a;
  assign load_b = (pin_b & oe_b) | ~oe_b;

  initial
  begin
    ext_pin = '0;
    sub_clk = 1'b0;
  end

  // count pin stands still between calls
  task automatic ext_set(input int n, input logic v, input int hold);
    @(posedge pclk);
    ext_pin[n] <= v;
    repeat (hold) @(posedge pclk);
  endtask

  task automatic sub_pulses(input int k);
    repeat (k)
    begin
      @(posedge pclk);
      sub_clk <= 1'b1;
      repeat (2) @(posedge pclk);
      sub_clk <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
endmodule // tmc_partner

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import tmc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [TMC_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sub;
  logic [TMC_NUM-1:0] ext, fo, foe, so, soe, ma, mp, lf, ls;
  int num_errors = 0;
  int n_checks = 0;

  always #12.5 pclk = ~pclk;

  tmc_top i_tmc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_input(ext), .sub_clock(sub),
    .timer_output_first(fo), .timer_output_first_oe(foe),
    .timer_output_second(so), .timer_output_second_oe(soe),
    .match_a_event(ma), .match_p_event(mp));
  tmc_partner i_tmc_partner (.pclk(pclk), .ext_pin(ext), .sub_clk(sub),
    .pin_a(fo), .oe_a(foe), .pin_b(so), .oe_b(soe), .load_a(lf),
    .load_b(ls));

  function automatic logic [7:0] ad(input int n, input logic [4:0] o);
    return {n[2:0], o};
  endfunction

  function automatic logic pl(input int n, input logic s);
    return s ? ls[n] : lf[n];
  endfunction

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic bound(input logic ok);
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("FAIL at %0t: wait ran out, got %h, expected %h", $time,
        ok, 1'b1);
      report_and_stop;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 40);
    bound(pready);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic cnt_is(input int n, input logic [9:0] x);
    logic [31:0] h;
    logic [31:0] l;
    logic e;
    apb(1'b0, ad(n, TMC_OFS_DH), 8'h00, h, e);
    apb(1'b0, ad(n, TMC_OFS_DL), 8'h00, l, e);
    chk({h[7:0], l[7:0]}, {22'h0, x});
  endtask

  // cycles between the last two of np event pulses
  task automatic gap(input int n, input bit p, input int np, input int lim,
    output int g);
    int k;
    logic s;
    k = 0;
    g = 0;
    s = 1'b0;
    for (int i = 0; i < np; i++)
    begin
      s = 1'b0;
      while (s !== 1'b1 && k < lim)
      begin
        @(posedge pclk);
        s = p ? mp[n] : ma[n];
        k++;
        g = (i == np - 1) ? g + 1 : g;
      end
    end
    bound(s);
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, TMC_OFS_PINSEL, 8'h00, r, e);
    chk(r, 32'h0);
    wr(TMC_OFS_PINSEL, 8'hFF);
    apb(1'b0, TMC_OFS_PINSEL, 8'h00, r, e);
    chk(r, 32'hF);
    chk({foe, soe}, 8'h00);
    apb(1'b0, 8'h18, 8'h00, r, e);
    chk(r, 32'h0);
    chk(e, 1'b1);
    $display("t_regs done");
  endtask

  task automatic t_pair;
    logic [31:0] r;
    logic e;
    wr(ad(0, TMC_OFS_AL), 8'h5A);
    apb(1'b0, ad(0, TMC_OFS_AH), 8'h00, r, e);
    apb(1'b0, ad(0, TMC_OFS_AL), 8'h00, r, e);
    chk(r, 32'h0);
    for (int n = 0; n < TMC_NUM; n++)
    begin
      wr(ad(n, TMC_OFS_AL), 8'hC3);
      wr(ad(n, TMC_OFS_AH), 8'hFF);
      apb(1'b0, ad(n, TMC_OFS_AH), 8'h00, r, e);
      chk(r, {24'h0, TMC_HI_MASK[n]});
      apb(1'b0, ad(n, TMC_OFS_AL), 8'h00, r, e);
      chk(r, 32'hC3);
    end
    $display("t_pair done");
  endtask

  task automatic t_clk;
    int dv [4] = '{4, 1, 16, 64};
    int g;
    wr(ad(0, TMC_OFS_AL), 8'h04);
    wr(ad(0, TMC_OFS_AH), 8'h00);
    wr(ad(0, TMC_OFS_C1), 8'hC1);
    for (int c = 0; c < 4; c++)
    begin
      wr(ad(0, TMC_OFS_C0), 8'h00);
      wr(ad(0, TMC_OFS_C0), {1'b0, c[2:0], 4'h8});
      gap(0, 1'b0, 3, 900, g);
      chk(g, 4 * dv[c]);
    end
    $display("t_clk done");
  endtask

  task automatic t_period;
    int g;
    wr(ad(0, TMC_OFS_C1), 8'hC0);
    for (int p = 0; p < 8; p++)
    begin
      wr(ad(0, TMC_OFS_C0), 8'h00);
      wr(ad(0, TMC_OFS_C0), {5'h3, p[2:0]});
      gap(0, 1'b1, 3, 3500, g);
      chk(g, p == 0 ? 1024 : p * 128);
    end
    $display("t_period done");
  endtask

  task automatic t_ext;
    for (int s = 6; s < 8; s++)
    begin
      wr(ad(0, TMC_OFS_C0), 8'h00);
      wr(ad(0, TMC_OFS_C0), {1'b0, s[2:0], 4'h8});
      i_tmc_partner.ext_set(0, 1'b1, s - 4);
      cnt_is(0, {9'h0, s == 6});
      i_tmc_partner.ext_set(0, 1'b0, s - 4);
      cnt_is(0, 10'h1);
    end
    i_tmc_partner.ext_set(0, 1'b1, 2);
    wr(ad(0, TMC_OFS_C0), 8'h70);
    i_tmc_partner.ext_set(0, 1'b0, 2);
    wr(ad(0, TMC_OFS_DH), 8'h03);
    cnt_is(0, 10'h1);
    wr(ad(0, TMC_OFS_C0), 8'h78);
    cnt_is(0, 10'h0);
    wr(ad(0, TMC_OFS_C0), 8'h00);
    wr(ad(0, TMC_OFS_C0), 8'h48);
    i_tmc_partner.sub_pulses(5);
    cnt_is(0, 10'h5);
    wr(ad(0, TMC_OFS_C0), 8'h00);
    wr(ad(0, TMC_OFS_C0), 8'h58);
    repeat (20) @(posedge pclk);
    cnt_is(0, 10'h0);
    $display("t_ext done");
  endtask

  task automatic t_out;
    logic oc;
    logic [3:0] ex;
    int g;
    int h;
    wr(ad(1, TMC_OFS_AL), 8'h28);
    wr(ad(1, TMC_OFS_AH), 8'h00);
    for (int io = 0; io < 4; io++)
    begin
      oc = (io != 2);
      wr(ad(1, TMC_OFS_C0), 8'h00);
      wr(TMC_OFS_PINSEL, {6'h0, io[0], 1'b0});
      wr(ad(1, TMC_OFS_C1), {2'b00, io[1:0], oc, 3'b001});
      wr(ad(1, TMC_OFS_C0), 8'h18);
      repeat (3) @(posedge pclk);
      chk({foe[1], soe[1], pl(1, io[0])}, {~io[0], io[0], oc});
      for (int k = 0; k < 2; k++)
      begin
        ex = k ? 4'hD : 4'h5;
        gap(1, 1'b0, 1, 100, g);
        repeat (2) @(posedge pclk);
        chk(pl(1, io[0]), ex[io]);
      end
    end
    wr(ad(1, TMC_OFS_C0), 8'h00);
    wr(ad(1, TMC_OFS_C1), 8'hC0);
    wr(ad(1, TMC_OFS_C0), 8'h18);
    repeat (2) @(posedge pclk);
    chk({foe[1], soe[1]}, 2'b00);
    wr(ad(2, TMC_OFS_AL), 8'h20);
    wr(ad(2, TMC_OFS_AH), 8'h00);
    wr(ad(2, TMC_OFS_C1), 8'hA8);
    wr(ad(2, TMC_OFS_C0), 8'h19);
    repeat (4) @(posedge pclk);
    h = 0;
    repeat (256)
    begin
      @(posedge pclk);
      h += (lf[2] === 1'b1);
    end
    chk(h, 64);
    $display("t_out done");
  endtask

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_pair;
    t_clk;
    t_period;
    t_ext;
    t_out;
    report_and_stop;
  end
endmodule // testbench
